// file: flash_write_status_report_tb.sv
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module flash_write_status_report_tb
    import fsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] SEC = 20'h3A010;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    fsr_mode_e mode = FSR_MODE_PROGRAM;
    logic abort = 1'b0;
    logic go = 1'b0;
    logic [1:0] op = 2'h0;
    logic [7:0] pd = 8'h00;
    logic lim = 1'b0;
    logic prot = 1'b0;
    logic [15:0] n_reads = 16'h0000;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    logic idle, res_valid, busy_seen, ce_n, oe_n, we_n, dq_oe, rb_pull;
    fsr_res_s res;
    logic [19:0] faddr;
    logic [7:0] dq_h, dq_m;
    wire logic [7:0] dq = dq_oe ? dq_h : dq_m;
    wire logic rb_n = ~rb_pull;
    always #5 clk = ~clk;
    fsr_host #(.AW(20)) u_dut (.clk(clk), .rst(rst), .start(start), .mode(mode), .addr(SEC),
        .exp_data(pd), .abort(abort), .idle(idle), .res_valid(res_valid), .res(res),
        .busy_seen(busy_seen), .flash_addr(faddr), .flash_ce_n(ce_n), .flash_oe_n(oe_n),
        .flash_we_n(we_n), .flash_dq_out(dq_h), .flash_dq_oe(dq_oe), .flash_dq_in(dq),
        .flash_ready_busy_n(rb_n));
    fsr_flash_model #(.AW(20)) u_mdl (.go(go), .op(op), .pd(pd), .lim(lim), .prot(prot),
        .n_reads(n_reads),
        .sa(SEC), .addr(faddr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq),
        .dq_o(dq_m), .rb_pull(rb_pull));
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            test_done();
        end
    end
    task automatic load(input logic [1:0] o, input logic [7:0] d, input logic l, input int n);
        @(negedge clk);
        op = o;
        pd = d;
        lim = l;
        n_reads = 16'(n);
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
    endtask
    task automatic run(input fsr_mode_e m, input logic ab);
        int i;
        @(negedge clk);
        mode = m;
        abort = ab;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        for (i = 0; i < 3000 && res_valid !== 1'b1; i++) @(negedge clk);
        `CHK("result pulse", 1'b1, res_valid)
        abort = 1'b0;
    endtask
    task automatic t_prog_poll();
        load(2'h1, 8'hA5, 1'b0, 3);
        run(FSR_MODE_PROGRAM, 1'b0);
        `CHK("prog result", RES_DONE, res.result)
        `CHK("prog data", 8'hA5, res.data)
        `CHK("prog busy seen", 1'b1, busy_seen)
        `CHK("prog ready after", 1'b1, rb_n)
    endtask
    task automatic t_erase_poll();
        load(2'h2, 8'h00, 1'b0, 3);
        run(FSR_MODE_ERASE, 1'b0);
        `CHK("erase result", RES_DONE, res.result)
        `CHK("erase data", 8'hFF, res.data)
    endtask
    task automatic t_toggle_done();
        load(2'h1, 8'h3A, 1'b0, 4);
        run(FSR_MODE_TOGGLE, 1'b0);
        `CHK("toggle result", RES_DONE, res.result)
        `CHK("toggle data", 8'h3A, res.data)
    endtask
    task automatic t_toggle_fail();
        load(2'h2, 8'h00, 1'b1, 2);
        run(FSR_MODE_TOGGLE, 1'b0);
        `CHK("toggle fail result", RES_FAIL, res.result)
        `CHK("ready after reset cmd", 1'b1, rb_n)
        lim = 1'b0;
    endtask
    task automatic t_poll_fail();
        load(2'h1, 8'h80, 1'b1, 2);
        run(FSR_MODE_PROGRAM, 1'b0);
        `CHK("poll fail result", RES_FAIL, res.result)
        `CHK("ready after poll fail", 1'b1, rb_n)
        lim = 1'b0;
    endtask
    task automatic t_suspend();
        load(2'h3, 8'h00, 1'b0, 0);
        run(FSR_MODE_TOGGLE, 1'b0);
        `CHK("suspend result", RES_SUSP, res.result)
        `CHK("suspend busy seen", 1'b0, busy_seen)
    endtask
    task automatic t_abort();
        load(2'h1, 8'h55, 1'b0, 1000);
        run(FSR_MODE_PROGRAM, 1'b1);
        `CHK("abort result", RES_NONE, res.result)
        `CHK("abort idle", 1'b1, idle)
        load(2'h0, 8'h00, 1'b0, 0);
    endtask
    task automatic t_protect();
        prot = 1'b1;
        load(2'h1, 8'h12, 1'b0, 2);
        run(FSR_MODE_TOGGLE, 1'b0);
        `CHK("protect result", RES_DONE, res.result)
        `CHK("protect data", 8'hFF, res.data)
        `CHK("protect busy seen", 1'b1, busy_seen)
        `CHK("protect ready after", 1'b1, rb_n)
        prot = 1'b0;
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        t_prog_poll();
        t_erase_poll();
        t_toggle_done();
        t_toggle_fail();
        t_poll_fail();
        t_suspend();
        t_abort();
        t_protect();
        test_done();
    end
endmodule
`default_nettype wire

// file: fsr_flash_model.sv
`default_nettype none
module fsr_flash_model
    import fsr_pkg::*;
#(
    parameter int AW = 20
) (
    input wire logic go,
    input wire logic [1:0] op,
    input wire logic [7:0] pd,
    input wire logic lim,
    input wire logic prot,
    input wire logic [15:0] n_reads,
    input wire logic [AW-1:0] sa,
    input wire logic [AW-1:0] addr,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [7:0] dq_in,
    output var logic [7:0] dq_o,
    output var logic rb_pull
);
    timeunit 1ns;
    timeprecision 1ps;
    // State: 0 array, 1 program, 2 erase, 3 erase suspended
    logic [1:0] st = 2'h0;
    logic [15:0] left = 16'h0000;
    logic tg1 = 1'b0;
    logic tg2 = 1'b0;
    logic [7:0] arr = 8'hFF;
    logic [7:0] stat;
    logic [7:0] last = 8'h00;
    wire logic rd = !ce_n && !oe_n;
    wire logic in_sec = addr[AW-1:12] == sa[AW-1:12];
    always_comb begin
        stat = 8'h00;
        stat[POLL_BIT_POS] = (st == 2'h1) ? ~pd[7] : (st == 2'h3);
        stat[TOG1_BIT_POS] = tg1;
        stat[LIMIT_BIT_POS] = lim && left == 16'h0000;
        stat[TOG2_BIT_POS] = tg2 && in_sec;
    end
    // Status replaces array data while busy
    assign dq_o = !rd ? ~last : (st == 2'h0 || (st == 2'h3 && !in_sec)) ? arr : stat;
    always @(dq_o or rd) if (rd) last = dq_o;
    assign rb_pull = st == 2'h1 || st == 2'h2;
    always @(posedge go) begin
        st <= op;
        left <= n_reads;
        tg1 <= 1'b0;
        tg2 <= 1'b0;
        // Protected target keeps its old contents; op 0 loads FF even when protected
        if (!prot || op == 2'h0) begin
            arr <= (op == 2'h1) ? pd : 8'hFF;
        end
    end
    always @(posedge oe_n) if (!ce_n) begin
        if (st == 2'h1 || st == 2'h2) begin
            tg1 <= ~tg1;
            if (left != 16'h0000) left <= left - 16'h0001;
            else if (!lim) st <= 2'h0;
        end
        if (st == 2'h2 || st == 2'h3) tg2 <= ~tg2;
    end
    always @(posedge we_n) if (!ce_n && dq_in == RESET_CMD) st <= 2'h0;
endmodule
`default_nettype wire

// file: fsr_host.sv
`default_nettype none
// Behaviour
// - Host reads the programmed address while polling a program.
// - Host reads inside a selected erase sector while polling an erase.
// - After polling shows true data, valid data comes on the next read.
// - Host reads twice, compares toggle bit; equal means done (code reports RES_SUSP instead when the TOG2_BIT_POS bit also differs).
// - Toggling with limit flag high: re-test, still toggling means failure, reset.
// - Host abandoning polling restarts toggle check from the first step.
// - After limit failure host writes reset, device returns to array read.
module fsr_host
    import fsr_pkg::*;
#(
    parameter int AW = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire fsr_mode_e mode,
    input wire logic [AW-1:0] addr,
    input wire logic [7:0] exp_data,
    input wire logic abort,
    output var logic idle,
    output var logic res_valid,
    output var fsr_res_s res,
    output var logic busy_seen,
    output var logic [AW-1:0] flash_addr,
    output var logic flash_ce_n,
    output var logic flash_oe_n,
    output var logic flash_we_n,
    output var logic [7:0] flash_dq_out,
    output var logic flash_dq_oe,
    input wire logic [7:0] flash_dq_in,
    input wire logic flash_ready_busy_n
);
    fsr_state_e state_ff, nxt_state;
    logic [3:0] cnt_ff;
    logic [1:0] rd_num_ff;
    logic [7:0] first_ff;
    logic [7:0] cur_ff;
    logic [2:0] rb_sync_ff;
    logic rb_level_ff;
    fsr_mode_e mode_ff;
    logic [7:0] exp_ff;
    logic [2:0] pend_res_ff;
    logic [7:0] dq_smp;
    logic cnt_done;
    logic tog_diff;
    logic poll_match;

    assign dq_smp = flash_dq_in;
    assign cnt_done = (cnt_ff == 4'h0);
    assign tog_diff = (cur_ff[TOG1_BIT_POS] != first_ff[TOG1_BIT_POS]);
    assign poll_match = (cur_ff[POLL_BIT_POS] == exp_ff[POLL_BIT_POS]);

    // Ready/busy synchroniser, open-drain line sampled only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rb_sync_ff <= 3'h7;
            rb_level_ff <= 1'b1;
        end else begin
            rb_sync_ff <= {rb_sync_ff[1:0], flash_ready_busy_n};
            if (rb_sync_ff[1] == rb_sync_ff[2]) begin
                rb_level_ff <= rb_sync_ff[2];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_seen <= 1'b0;
        end else if (!rb_level_ff) begin
            busy_seen <= 1'b1;
        end else if (start && state_ff == FSR_IDLE) begin
            busy_seen <= 1'b0;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            FSR_IDLE: if (start) nxt_state = FSR_SETUP;
            FSR_SETUP: if (cnt_done) nxt_state = FSR_PULSE;
            FSR_PULSE: if (cnt_done) nxt_state = FSR_HOLD;
            FSR_HOLD: if (cnt_done) nxt_state = FSR_EVAL;
            FSR_EVAL: begin
                if (abort) begin
                    nxt_state = FSR_REPORT;
                end else if (mode_ff != FSR_MODE_TOGGLE) begin
                    if (poll_match) begin
                        nxt_state = (rd_num_ff == 2'h3) ? FSR_REPORT : FSR_SETUP;
                    end else if (cur_ff[LIMIT_BIT_POS] && rd_num_ff == 2'h2) begin
                        nxt_state = FSR_WSETUP;
                    end else begin
                        nxt_state = FSR_SETUP;
                    end
                end else if (rd_num_ff == 2'h0) begin
                    nxt_state = FSR_SETUP;
                end else if (!tog_diff) begin
                    nxt_state = FSR_REPORT;
                end else if (cur_ff[LIMIT_BIT_POS] && rd_num_ff == 2'h2) begin
                    nxt_state = FSR_WSETUP;
                end else begin
                    nxt_state = FSR_SETUP;
                end
            end
            FSR_WSETUP: if (cnt_done) nxt_state = FSR_WPULSE;
            FSR_WPULSE: if (cnt_done) nxt_state = FSR_WHOLD;
            FSR_WHOLD: if (cnt_done) nxt_state = FSR_REPORT;
            FSR_REPORT: nxt_state = FSR_IDLE;
            default: nxt_state = FSR_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= FSR_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff <= 4'h0;
        end else if (nxt_state != state_ff) begin
            case (nxt_state)
                FSR_SETUP, FSR_WSETUP: cnt_ff <= 4'(SETUP_CYC - 1);
                FSR_PULSE, FSR_WPULSE: cnt_ff <= 4'(PULSE_CYC - 1);
                FSR_HOLD, FSR_WHOLD: cnt_ff <= 4'(OEH_CYC - 1);
                default: cnt_ff <= 4'h0;
            endcase
        end else if (!cnt_done) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    // Read capture and toggle tracking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_ff <= FSR_MODE_PROGRAM;
            exp_ff <= DATA_RST;
            flash_addr <= '0;
            rd_num_ff <= 2'h0;
            first_ff <= DATA_RST;
            cur_ff <= DATA_RST;
            pend_res_ff <= RES_NONE;
        end else begin
            if (state_ff == FSR_IDLE && start) begin
                mode_ff <= mode;
                exp_ff <= (mode == FSR_MODE_ERASE) ? 8'hFF : exp_data;
                flash_addr <= addr;
                rd_num_ff <= 2'h0;
            end
            if (state_ff == FSR_PULSE && cnt_done) begin
                cur_ff <= dq_smp;
            end
            if (state_ff == FSR_EVAL) begin
                first_ff <= cur_ff;
                if (mode_ff == FSR_MODE_TOGGLE) begin
                    if (rd_num_ff == 2'h0 || !cur_ff[LIMIT_BIT_POS]) begin
                        rd_num_ff <= 2'h1;
                    end else begin
                        rd_num_ff <= 2'h2;
                    end
                end else if (poll_match) begin
                    rd_num_ff <= 2'h3;
                end else if (cur_ff[LIMIT_BIT_POS]) begin
                    rd_num_ff <= 2'h2;
                end
                if (abort) begin
                    pend_res_ff <= RES_NONE;
                end else if (nxt_state == FSR_WSETUP) begin
                    pend_res_ff <= RES_FAIL;
                end else if (mode_ff == FSR_MODE_TOGGLE) begin
                    pend_res_ff <= cur_ff[TOG2_BIT_POS] != first_ff[TOG2_BIT_POS] ?
                        RES_SUSP : RES_DONE;
                end else begin
                    pend_res_ff <= RES_DONE;
                end
            end
        end
    end

    // Bus strobes, all registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
            flash_dq_oe <= 1'b0;
            flash_dq_out <= DATA_RST;
        end else begin
            flash_ce_n <= !(nxt_state inside {FSR_SETUP, FSR_PULSE, FSR_HOLD,
                FSR_WSETUP, FSR_WPULSE, FSR_WHOLD});
            flash_oe_n <= (nxt_state != FSR_PULSE);
            flash_we_n <= (nxt_state != FSR_WPULSE);
            flash_dq_oe <= (nxt_state inside {FSR_WSETUP, FSR_WPULSE, FSR_WHOLD});
            flash_dq_out <= RESET_CMD;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle <= 1'b1;
            res_valid <= 1'b0;
            res <= '0;
        end else begin
            idle <= (nxt_state == FSR_IDLE);
            res_valid <= (state_ff == FSR_REPORT);
            if (state_ff == FSR_REPORT) begin
                res.result <= pend_res_ff;
                res.data <= cur_ff;
            end
        end
    end

    a_poll_done: assert property (@(posedge clk) disable iff (rst)
        (state_ff == FSR_EVAL && mode_ff != FSR_MODE_TOGGLE && rd_num_ff == 2'h3 &&
         poll_match && !abort) |-> ##2 res_valid && res.result == RES_DONE)
        else $error("poll done not reported");
    a_toggle_done: assert property (@(posedge clk) disable iff (rst)
        (state_ff == FSR_EVAL && mode_ff == FSR_MODE_TOGGLE && rd_num_ff != 2'h0 &&
         !tog_diff && !abort) |=> state_ff == FSR_REPORT)
        else $error("equal toggle reads did not end check");
    a_fail_reset: assert property (@(posedge clk) disable iff (rst)
        (state_ff == FSR_EVAL && nxt_state == FSR_WSETUP) |->
        ##[1:20] (!flash_we_n && flash_dq_oe && flash_dq_out == RESET_CMD))
        else $error("reset command not written after failure");
    a_no_fight: assert property (@(posedge clk) disable iff (rst)
        !(flash_dq_oe && !flash_oe_n))
        else $error("data bus driven during read");
    a_read_addr: assert property (@(posedge clk) disable iff (rst)
        !flash_oe_n |-> $stable(flash_addr))
        else $error("address moved during status read");
    a_first_read: assert property (@(posedge clk) disable iff (rst)
        (state_ff == FSR_IDLE && start) |=> rd_num_ff == 2'h0 ##1 !flash_ce_n)
        else $error("toggle check did not restart");
    a_read_pulse: assert property (@(posedge clk) disable iff (rst)
        $fell(flash_oe_n) |-> !flash_oe_n [*2])
        else $error("read pulse too short");
    a_busy_flag: assert property (@(posedge clk) disable iff (rst)
        (!rb_level_ff && !(start && state_ff == FSR_IDLE)) |=> busy_seen)
        else $error("busy level not recorded");
    c_done: cover property (@(posedge clk) res_valid && res.result == RES_DONE);
    c_fail: cover property (@(posedge clk) res_valid && res.result == RES_FAIL);
    c_susp: cover property (@(posedge clk) res_valid && res.result == RES_SUSP);
    c_busy: cover property (@(posedge clk) busy_seen && res_valid);
endmodule
`default_nettype wire

// file: fsr_pkg.sv
`default_nettype none
package fsr_pkg;
    localparam int CLK_MHZ = 100;
    localparam int T_SETUP_NS = 30;
    localparam int T_PULSE_NS = 50;
    localparam int T_OEH_NS = 20;
    localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int OEH_CYC = (T_OEH_NS * CLK_MHZ + 999) / 1000;
    localparam int POLL_BIT_POS = 7;
    localparam int TOG1_BIT_POS = 6;
    localparam int LIMIT_BIT_POS = 5;
    localparam int TOG2_BIT_POS = 2;
    localparam logic [7:0] RESET_CMD = 8'hF0;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [2:0] RES_NONE = 3'h0;
    localparam logic [2:0] RES_DONE = 3'h1;
    localparam logic [2:0] RES_FAIL = 3'h2;
    localparam logic [2:0] RES_SUSP = 3'h3;
    localparam logic [2:0] RES_BUSY = 3'h4;

    typedef enum logic [1:0] {
        FSR_MODE_PROGRAM = 2'b00,
        FSR_MODE_ERASE = 2'b01,
        FSR_MODE_TOGGLE = 2'b10
    } fsr_mode_e;

    typedef struct packed {
        logic [7:0] data;
        logic [2:0] result;
    } fsr_res_s;

    typedef enum logic [3:0] {
        FSR_IDLE = 4'b0000,
        FSR_SETUP = 4'b0001,
        FSR_PULSE = 4'b0010,
        FSR_HOLD = 4'b0011,
        FSR_EVAL = 4'b0100,
        FSR_WSETUP = 4'b0101,
        FSR_WPULSE = 4'b0110,
        FSR_WHOLD = 4'b0111,
        FSR_REPORT = 4'b1000
    } fsr_state_e;
endpackage
`default_nettype wire
